// ---- src/fpi_core.sv ----
`timescale 1ns/100ps
module fpi_core #(
  parameter logic [fpi_pkg::SEC_W-1:0] SEC_CYC = fpi_pkg::SEC_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // flow pins, high = closed
  input wire logic pin_odd_in,
  input wire logic pin_even_in,
  // flow configuration
  input wire fpi_pkg::fpi_func_t odd_func_in,
  input wire logic even_uni_in,
  input wire fpi_pkg::fpi_pincfg_t pin_cfg_in,
  input wire logic store_indep_in,
  input wire logic [fpi_pkg::DIV_W-1:0] sample_div_in,
  input wire logic log_tick_in,
  // flow results
  output logic [fpi_pkg::CNT_W-1:0] fwd_count_out,
  output logic [fpi_pkg::CNT_W-1:0] rev_count_out,
  output logic [fpi_pkg::CNT_W:0] net_count_out,
  output logic [fpi_pkg::CNT_W-1:0] even_count_out,
  output logic indep_out,
  output logic result_valid_out,
  // trigger configuration and channel value
  input wire logic trig_en_in,
  input wire logic [fpi_pkg::VAL_W-1:0] chan_value_in,
  input wire logic value_valid_in,
  input wire logic [fpi_pkg::VAL_W-1:0] thr_a_in,
  input wire logic [fpi_pkg::WIN_W-1:0] cnt_c_in,
  input wire logic [fpi_pkg::WIN_W-1:0] win_d_in,
  input wire logic [fpi_pkg::VAL_W-1:0] hyst_in,
  input wire logic out_sel_in,
  input wire logic [fpi_pkg::DUR_W-1:0] dur_y_in,
  // status contacts, high = closed
  output logic [1:0] contact_out,
  output logic trig_active_out
);
  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers
  function automatic logic [1:0] quad_step(input logic [1:0] prv, input logic [1:0] cur);
    // bit1 forward, bit0 reverse
    case ({prv, cur})
      4'h1, 4'h7, 4'he, 4'h8: quad_step = 2'h2;
      4'h2, 4'hb, 4'hd, 4'h4: quad_step = 2'h1;
      default: quad_step = 2'h0;
    endcase
  endfunction : quad_step

  function automatic logic [fpi_pkg::WIN_W-1:0] win_count(
    input logic [fpi_pkg::WIN_MAX-1:0] hist, input logic [fpi_pkg::WIN_W-1:0] d);
    logic [fpi_pkg::WIN_W-1:0] n;
    n = '0;
    for (int i = 0; i < fpi_pkg::WIN_MAX; i++) begin
      if (i < int'(d) && hist[i]) begin
        n = n + 4'h1;
      end
    end
    win_count = n;
  endfunction : win_count

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  assign pin_raw = {pin_odd_in, pin_even_in};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    fpi_sync u_sync (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .pin_in(pin_raw[g]),
      .level_out(pin_lvl[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling interval
  logic [fpi_pkg::DIV_W-1:0] div_cnt_r;
  logic samp_en_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div_cnt_r <= '0;
      samp_en_r <= 1'b0;
    end else if (div_cnt_r == '0) begin
      div_cnt_r <= sample_div_in;
      samp_en_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r - 16'h0001;
      samp_en_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampled levels and transitions
  logic [1:0] samp_r;
  logic [1:0] rise;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      samp_r <= 2'h0;
    end else if (samp_en_r) begin
      samp_r <= pin_lvl;
    end
  end

  assign rise = samp_en_r ? (pin_lvl & ~samp_r) : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership and count increments
  logic even_claimed;
  logic even_uni_act;
  logic [1:0] qstep;
  logic fwd_inc;
  logic rev_inc;
  logic even_inc;

  assign even_claimed = (odd_func_in == fpi_pkg::FN_BI);
  assign even_uni_act = even_uni_in && !even_claimed;
  assign qstep = samp_en_r ? quad_step(samp_r, pin_lvl) : 2'h0;

  always_comb begin
    fwd_inc = 1'b0;
    rev_inc = 1'b0;
    case (odd_func_in)
      fpi_pkg::FN_UNI: begin
        fwd_inc = rise[fpi_pkg::PIN_ODD];
      end
      fpi_pkg::FN_BI: begin
        case (pin_cfg_in)
          fpi_pkg::PC_PULSE_DIR: begin
            fwd_inc = rise[fpi_pkg::PIN_ODD] && !pin_lvl[fpi_pkg::PIN_EVEN];
            rev_inc = rise[fpi_pkg::PIN_ODD] && pin_lvl[fpi_pkg::PIN_EVEN];
          end
          fpi_pkg::PC_FWD_REV: begin
            fwd_inc = rise[fpi_pkg::PIN_ODD];
            rev_inc = rise[fpi_pkg::PIN_EVEN];
          end
          fpi_pkg::PC_QUAD: begin
            fwd_inc = qstep[1];
            rev_inc = qstep[0];
          end
          default: begin
            fwd_inc = 1'b0;
          end
        endcase
      end
      default: begin
        fwd_inc = 1'b0;
      end
    endcase
  end

  assign even_inc = even_uni_act && rise[fpi_pkg::PIN_EVEN];

  ////////////////////////////////////////////////////////////////////////////
  // per-period counters
  logic [fpi_pkg::CNT_W-1:0] fwd_r;
  logic [fpi_pkg::CNT_W-1:0] rev_r;
  logic [fpi_pkg::CNT_W-1:0] even_r;
  logic [fpi_pkg::CNT_W-1:0] fwd_nxt;
  logic [fpi_pkg::CNT_W-1:0] rev_nxt;
  logic [fpi_pkg::CNT_W-1:0] even_nxt;

  assign fwd_nxt = fwd_r + {15'h0000, fwd_inc};
  assign rev_nxt = rev_r + {15'h0000, rev_inc};
  assign even_nxt = even_r + {15'h0000, even_inc};

  // a pulse on the boundary cycle opens the new period
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fwd_r <= fpi_pkg::CNT_RST;
      rev_r <= fpi_pkg::CNT_RST;
      even_r <= fpi_pkg::CNT_RST;
    end else if (log_tick_in) begin
      fwd_r <= {15'h0000, fwd_inc};
      rev_r <= {15'h0000, rev_inc};
      even_r <= {15'h0000, even_inc};
    end else begin
      fwd_r <= fwd_nxt;
      rev_r <= rev_nxt;
      even_r <= even_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fwd_count_out <= fpi_pkg::CNT_RST;
      rev_count_out <= fpi_pkg::CNT_RST;
      net_count_out <= '0;
      even_count_out <= fpi_pkg::CNT_RST;
      indep_out <= 1'b0;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= log_tick_in;
      if (log_tick_in) begin
        fwd_count_out <= fwd_r;
        rev_count_out <= rev_r;
        net_count_out <= {1'b0, fwd_r} - {1'b0, rev_r};
        even_count_out <= even_r;
        indep_out <= store_indep_in && (odd_func_in == fpi_pkg::FN_BI)
          && (pin_cfg_in == fpi_pkg::PC_PULSE_DIR);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger evaluation
  fpi_pkg::fpi_trig_t trig_r;
  logic [fpi_pkg::WIN_MAX-1:0] hist_r;
  logic [fpi_pkg::WIN_MAX-1:0] hist_nxt;
  logic [fpi_pkg::VAL_W-1:0] clr_lvl;
  logic fire;

  assign hist_nxt = {hist_r[fpi_pkg::WIN_MAX-2:0], chan_value_in > thr_a_in};
  assign clr_lvl = (thr_a_in > hyst_in) ? thr_a_in - hyst_in : '0;
  assign fire = trig_en_in && value_valid_in && (trig_r == fpi_pkg::TS_IDLE)
    && (cnt_c_in != '0) && (win_count(hist_nxt, win_d_in) >= cnt_c_in);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hist_r <= fpi_pkg::HIST_RST;
    end else if (value_valid_in) begin
      hist_r <= hist_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trig_r <= fpi_pkg::TS_IDLE;
    end else begin
      case (trig_r)
        fpi_pkg::TS_IDLE: begin
          if (fire) begin
            trig_r <= fpi_pkg::TS_FIRED;
          end
        end
        fpi_pkg::TS_FIRED: begin
          if (!trig_en_in || (value_valid_in && chan_value_in <= clr_lvl)) begin
            trig_r <= fpi_pkg::TS_IDLE;
          end
        end
        default: begin
          trig_r <= fpi_pkg::TS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output action timer
  logic [fpi_pkg::SEC_W-1:0] sec_cnt_r;
  logic [fpi_pkg::DUR_W-1:0] sec_left_r;
  logic sel_r;
  logic sec_end;

  assign sec_end = (sec_cnt_r == SEC_CYC - 24'h000001);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sec_cnt_r <= '0;
      sec_left_r <= '0;
      sel_r <= 1'b0;
    end else if (fire) begin
      sec_cnt_r <= '0;
      sec_left_r <= dur_y_in;
      sel_r <= out_sel_in;
    end else if (sec_left_r != '0) begin
      if (sec_end) begin
        sec_cnt_r <= '0;
        sec_left_r <= sec_left_r - 8'h01;
      end else begin
        sec_cnt_r <= sec_cnt_r + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      contact_out <= fpi_pkg::CONTACT_RST;
      trig_active_out <= 1'b0;
    end else begin
      trig_active_out <= (trig_r == fpi_pkg::TS_FIRED);
      contact_out[0] <= (sec_left_r != '0) && !sel_r;
      contact_out[1] <= (sec_left_r != '0) && sel_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  fwd_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (odd_func_in == fpi_pkg::FN_UNI && rise[1] && !log_tick_in)
      |=> fwd_r == $past(fwd_r) + 16'h0001)
    else $error("uni pulse not counted");
  even_claim_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (even_claimed && !log_tick_in) |=> even_r == $past(even_r))
    else $error("claimed even pin counted alone");
  samp_space_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (samp_en_r && sample_div_in != '0) |=> !samp_en_r)
    else $error("sample enables too close");
  samp_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !samp_en_r |=> samp_r == $past(samp_r))
    else $error("sampled level moved off enable");
  // forward step 00 -> 01, code is {odd, even}
  quad_fwd_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (odd_func_in == fpi_pkg::FN_BI && pin_cfg_in == fpi_pkg::PC_QUAD && samp_en_r
      && samp_r == 2'h0 && pin_lvl == 2'h1) |-> fwd_inc && !rev_inc)
    else $error("quadrature forward step missed");

  dir_rev_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (odd_func_in == fpi_pkg::FN_BI && pin_cfg_in == fpi_pkg::PC_PULSE_DIR
      && rise[1] && pin_lvl[0] && !log_tick_in) |=> rev_r == $past(rev_r) + 16'h0001)
    else $error("reverse pulse not counted");

  handover_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    log_tick_in |=> fwd_count_out == $past(fwd_r) && fwd_r == {15'h0000, $past(fwd_inc)}
      && result_valid_out)
    else $error("boundary lost counts");

  fire_out_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (fire && dur_y_in != '0) |=> ##1 (contact_out[$past(out_sel_in, 2)] && trig_active_out))
    else $error("fired trigger did not close contact");

  fire_cond_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(trig_r == fpi_pkg::TS_FIRED) |-> $past(value_valid_in && trig_en_in))
    else $error("trigger fired without a sample");

  contact_end_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (sec_left_r == 8'h01 && sec_end && !fire) |=> ##1 contact_out == 2'h0)
    else $error("contact held past duration");

  quad_cov_c: cover property (@(posedge mclk_in) disable iff (rst_in)
    pin_cfg_in == fpi_pkg::PC_QUAD && qstep == 2'h1);
  fire_cov_c: cover property (@(posedge mclk_in) disable iff (rst_in) fire);
  edge_tick_c: cover property (@(posedge mclk_in) disable iff (rst_in)
    log_tick_in && fwd_inc);
endmodule : fpi_core

// ---- src/fpi_pkg.sv ----
package fpi_pkg;
  localparam int CNT_W = 16;
  localparam int VAL_W = 16;
  localparam int DIV_W = 16;
  localparam int DUR_W = 8;
  localparam int SEC_W = 24;
  localparam int WIN_MAX = 8;
  localparam int WIN_W = 4;
  localparam int SYNC_STAGES = 3;
  localparam int SEC_TIME_MS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEC_CYC_I = SEC_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [SEC_W-1:0] SEC_CYC = SEC_W'(SEC_CYC_I);
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [WIN_MAX-1:0] HIST_RST = 8'h00;
  localparam logic [1:0] CONTACT_RST = 2'h0;
  localparam int PIN_ODD = 1;
  localparam int PIN_EVEN = 0;

  typedef enum logic [1:0] {FN_OFF, FN_UNI, FN_BI} fpi_func_t;
  typedef enum logic [1:0] {PC_PULSE_DIR, PC_FWD_REV, PC_QUAD} fpi_pincfg_t;
  typedef enum logic {TS_IDLE, TS_FIRED} fpi_trig_t;
endpackage : fpi_pkg

// ---- src/fpi_sync.sv ----
`timescale 1ns/100ps
module fpi_sync (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // raw pin and settled level
  input wire logic pin_in,
  output logic level_out
);
  logic [fpi_pkg::SYNC_STAGES-1:0] chain_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[fpi_pkg::SYNC_STAGES-2:0], pin_in};
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (chain_r[1] == chain_r[2]) begin
      level_out <= chain_r[2];
    end
  end
endmodule : fpi_sync

// ---- test/fpi_meter.sv ----
`timescale 1ns/100ps
module fpi_meter (
  // clock
  input wire logic mclk_in,
  // meter pins, high = closed
  output logic pin_odd_out,
  output logic pin_even_out,
  // switched equipment
  input wire logic [1:0] contact_in,
  input wire logic clr_in
);
  int closed_cyc [2];

  initial begin
    pin_odd_out = 1'b0;
    pin_even_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // set both pins, then hold them ten cycles
  task automatic drive(input logic odd, input logic even);
    @(posedge mclk_in);
    pin_odd_out <= odd;
    pin_even_out <= even;
    repeat (10) @(posedge mclk_in);
  endtask : drive

  ////////////////////////////////////////////////////////////////
  // equipment counts the cycles each contact is closed
  always @(posedge mclk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (clr_in) closed_cyc[i] <= 0;
      else if (contact_in[i] === 1'b1) closed_cyc[i] <= closed_cyc[i] + 1;
    end
  end
endmodule : fpi_meter

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pin_odd, pin_even;
  fpi_pkg::fpi_func_t odd_func = fpi_pkg::FN_OFF;
  fpi_pkg::fpi_pincfg_t pin_cfg = fpi_pkg::PC_PULSE_DIR;
  logic even_uni = 1'b0, store_indep = 1'b0, log_tick = 1'b0;
  logic [15:0] fwd, rev, evn, chan_value = 16'h0000;
  logic [16:0] net;
  logic indep, rvalid, trig_en = 1'b0, vvalid = 1'b0, out_sel = 1'b0, trig_act, clr = 1'b0;
  logic [3:0] cnt_c = 4'h2, win_d = 4'h3;
  logic [7:0] dur_y = 8'h02;
  logic [15:0] samp_div = 16'h0001;
  logic [1:0] contact;
  int n_errors = 0;
  int cmp_count = 0;

  always #50 mclk_in = ~mclk_in;

  fpi_core #(.SEC_CYC(24'h000014)) u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .pin_odd_in(pin_odd), .pin_even_in(pin_even),
    .odd_func_in(odd_func), .even_uni_in(even_uni), .pin_cfg_in(pin_cfg),
    .store_indep_in(store_indep), .sample_div_in(samp_div), .log_tick_in(log_tick),
    .fwd_count_out(fwd), .rev_count_out(rev), .net_count_out(net), .even_count_out(evn),
    .indep_out(indep), .result_valid_out(rvalid), .trig_en_in(trig_en),
    .chan_value_in(chan_value), .value_valid_in(vvalid), .thr_a_in(16'h0032),
    .cnt_c_in(cnt_c), .win_d_in(win_d), .hyst_in(16'h000a), .out_sel_in(out_sel),
    .dur_y_in(dur_y), .contact_out(contact), .trig_active_out(trig_act)
  );

  fpi_meter u_meter (
    .mclk_in(mclk_in), .pin_odd_out(pin_odd), .pin_even_out(pin_even),
    .contact_in(contact), .clr_in(clr)
  );

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // boundary pulse, then wait for the result strobe
  task automatic tick();
    logic seen;
    seen = 1'b0;
    repeat (12) @(posedge mclk_in);
    log_tick <= 1'b1;
    @(posedge mclk_in);
    log_tick <= 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      @(negedge mclk_in);
      seen = (rvalid === 1'b1);
    end
    @(posedge mclk_in);
    chk("result_valid", seen, 1);
  endtask : tick

  task automatic pulse(input logic even_lvl, input int n);
    repeat (n) begin
      u_meter.drive(1'b1, even_lvl);
      u_meter.drive(1'b0, even_lvl);
    end
  endtask : pulse

  task automatic val(input logic [15:0] v);
    @(posedge mclk_in);
    chan_value <= v;
    vvalid <= 1'b1;
    @(posedge mclk_in);
    vvalid <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask : val

  ////////////////////////////////////////////////////////////////
  task automatic t_uni();
    odd_func <= fpi_pkg::FN_UNI;
    even_uni <= 1'b1;
    tick();
    pulse(1'b0, 3);
    u_meter.drive(1'b0, 1'b1);
    u_meter.drive(1'b0, 1'b0);
    tick();
    chk("uni_fwd", 17'(fwd), 17'h00003);
    chk("uni_even", 17'(evn), 17'h00001);
    tick();
    chk("empty_fwd", 17'(fwd), 17'h00000);
    $display("test uni done");
  endtask : t_uni

  task automatic t_pd();
    odd_func <= fpi_pkg::FN_BI;
    pin_cfg <= fpi_pkg::PC_PULSE_DIR;
    store_indep <= 1'b1;
    tick();
    pulse(1'b0, 2);
    pulse(1'b1, 1);
    u_meter.drive(1'b0, 1'b0);
    tick();
    chk("pd_fwd", 17'(fwd), 17'h00002);
    chk("pd_rev", 17'(rev), 17'h00001);
    chk("pd_net", net, 17'h00001);
    chk("pd_indep", 17'(indep), 17'h00001);
    chk("pd_even", 17'(evn), 17'h00000);
    store_indep <= 1'b0;
    $display("test pulse direction done");
  endtask : t_pd

  task automatic t_fr();
    pin_cfg <= fpi_pkg::PC_FWD_REV;
    samp_div <= 16'h0003;
    tick();
    pulse(1'b0, 3);
    u_meter.drive(1'b0, 1'b1);
    u_meter.drive(1'b0, 1'b0);
    tick();
    chk("fr_fwd", 17'(fwd), 17'h00003);
    chk("fr_rev", 17'(rev), 17'h00001);
    chk("fr_net", net, 17'h00002);
    chk("fr_even", 17'(evn), 17'h00000);
    chk("fr_indep", 17'(indep), 17'h00000);
    $display("test fwd rev done");
  endtask : t_fr

  task automatic t_quad();
    logic [1:0] codes [8] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h0};
    pin_cfg <= fpi_pkg::PC_QUAD;
    tick();
    foreach (codes[i]) u_meter.drive(codes[i][1], codes[i][0]);
    tick();
    chk("quad_net", net, 17'h00004);
    chk("quad_fwd", 17'(fwd), 17'h00006);
    chk("quad_rev", 17'(rev), 17'h00002);
    $display("test quadrature done");
  endtask : t_quad

  task automatic t_off();
    odd_func <= fpi_pkg::FN_OFF;
    tick();
    pulse(1'b0, 1);
    u_meter.drive(1'b0, 1'b1);
    u_meter.drive(1'b0, 1'b0);
    tick();
    chk("off_fwd", 17'(fwd), 17'h00000);
    chk("off_even", 17'(evn), 17'h00001);
    $display("test odd off done");
  endtask : t_off

  task automatic t_trig();
    trig_en <= 1'b1;
    out_sel <= 1'b1;
    clr <= 1'b1;
    @(posedge mclk_in);
    clr <= 1'b0;
    val(16'h003c);
    val(16'h000a);
    chk("no_fire", 17'(trig_act), 17'h00000);
    val(16'h003c);
    chk("fired", 17'(trig_act), 17'h00001);
    repeat (60) @(posedge mclk_in);
    chk("c1_len", 17'(u_meter.closed_cyc[1] inside {[39:41]}), 17'h00001);
    chk("c0_len", 17'(u_meter.closed_cyc[0]), 17'h00000);
    chk("c_idle", 17'(contact), 17'h00000);
    val(16'h002d);
    val(16'h003c);
    val(16'h003c);
    repeat (10) @(posedge mclk_in);
    chk("hyst_hold", 17'(trig_act), 17'h00001);
    chk("no_refire", 17'(u_meter.closed_cyc[1] inside {[39:41]}), 17'h00001);
    val(16'h001e);
    chk("cleared", 17'(trig_act), 17'h00000);
    out_sel <= 1'b0;
    dur_y <= 8'h01;
    val(16'h003c);
    val(16'h003c);
    repeat (40) @(posedge mclk_in);
    chk("c0_len2", 17'(u_meter.closed_cyc[0] inside {[19:21]}), 17'h00001);
    chk("fired2", 17'(trig_act), 17'h00001);
    trig_en <= 1'b0;
    repeat (3) @(posedge mclk_in);
    chk("en_clear", 17'(trig_act), 17'h00000);
    $display("test trigger done");
  endtask : t_trig

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk("rst_contact", 17'(contact), 17'h00000);
    t_uni();
    t_pd();
    t_fr();
    t_quad();
    t_off();
    t_trig();
    close_out();
  end

  initial begin
    #3000000;
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
endmodule : testbench
